// ### rtl/rwd_pkg.sv
package rwd_pkg;
  // Register page: the top sixteen bytes of the address space
  localparam int ADDR_W = 19;
  localparam logic [18:0] OFS_FLAGS = 19'h7fff0;
  localparam logic [18:0] OFS_SPARE = 19'h7fff1;
  localparam logic [18:0] OFS_ALM_SEC = 19'h7fff2;
  localparam logic [18:0] OFS_ALM_EN = 19'h7fff6;
  localparam logic [18:0] OFS_WD_SETTING = 19'h7fff7;
  localparam logic [18:0] OFS_CLK_CTRL = 19'h7fff8;
  localparam logic [18:0] OFS_SEC_COUNT = 19'h7fff9;
  localparam logic [18:0] OFS_MIN_COUNT = 19'h7fffa;
  localparam logic [18:0] OFS_HOUR_COUNT = 19'h7fffb;
  localparam logic [18:0] OFS_WDAY_COUNT = 19'h7fffc;
  localparam logic [18:0] OFS_DATE_COUNT = 19'h7fffd;
  localparam logic [18:0] OFS_MONTH_COUNT = 19'h7fffe;
  localparam logic [18:0] OFS_YEAR_COUNT = 19'h7ffff;
  // Byte positions inside the 64-bit time image (offsets 8..f)
  localparam int B_CENT = 8 * int'(OFS_CLK_CTRL[2:0]);
  localparam int B_SEC = 8 * int'(OFS_SEC_COUNT[2:0]);
  localparam int B_MIN = 8 * int'(OFS_MIN_COUNT[2:0]);
  localparam int B_HOUR = 8 * int'(OFS_HOUR_COUNT[2:0]);
  localparam int B_WDAY = 8 * int'(OFS_WDAY_COUNT[2:0]);
  localparam int B_DATE = 8 * int'(OFS_DATE_COUNT[2:0]);
  localparam int B_MONTH = 8 * int'(OFS_MONTH_COUNT[2:0]);
  localparam int B_YEAR = 8 * int'(OFS_YEAR_COUNT[2:0]);
  localparam logic [63:0] TIME_MASK = 64'hff1f3f073f7f7f3f;
  // Bit positions
  localparam int HALT_BIT = 7;
  localparam int FTEST_BIT = 6;
  localparam int WR_HOLD_BIT = 7;
  localparam int RD_HOLD_BIT = 6;
  localparam int AIE_BIT = 7;
  localparam int ABE_BIT = 5;
  localparam int WF_BIT = 7;
  localparam int AF_BIT = 6;
  localparam int BLF_BIT = 4;
  localparam int WDS_BIT = 7;
  localparam int WD_MULT_LSB = 2;
  localparam int WD_MULT_W = 5;
  localparam int AM_BIT = 7;
  // Power-on values
  localparam logic [7:0] WD_SETTING_RST = 8'h00;
  localparam logic [7:0] ALM_EN_RST = 8'h00;
  localparam logic FTEST_RST = 1'b0;
  // Alarm mask patterns, AM4..AM1
  localparam logic [3:0] AM_EVERY = 4'b1111;
  localparam logic [3:0] AM_SEC = 4'b1110;
  localparam logic [3:0] AM_MIN = 4'b1100;
  localparam logic [3:0] AM_HOUR = 4'b1000;
  localparam logic [3:0] AM_DATE = 4'b0000;
  // Calendar limits in BCD
  localparam logic [7:0] MINSEC_LAST = 8'h59;
  localparam logic [7:0] HOUR_LAST = 8'h23;
  localparam logic [7:0] WDAY_LAST = 8'h07;
  localparam logic [7:0] MONTH_LAST = 8'h12;
  localparam logic [7:0] YEAR_LAST = 8'h99;
  localparam logic [7:0] CENT_LAST = 8'h39;
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] FEB = 8'h02;
  // Timing
  localparam int XTAL_HZ = 32768;
  localparam int DIV_W = $clog2(XTAL_HZ);
  localparam int TEST_DIV_BIT = 5;
  localparam int SIXTEENTH_SHIFT = 11;
  localparam int WD_CNT_W = 22;
  localparam int CLK_HZ = 50_000_000;
  localparam int READ_RELEASE_US = 500;
  localparam int READ_RELEASE_CYC =
    (READ_RELEASE_US * (CLK_HZ / 1000) + 999) / 1000;
endpackage

// ### rtl/rwd_calendar.sv
`timescale 1ns/100ps
`default_nettype none
module rwd_calendar
  import rwd_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic load,
  input wire logic [63:0] load_image,
  output logic [63:0] time_image
);
  typedef struct packed {
    logic [63:0] img;
  } rwd_cal_t;

  rwd_cal_t st;
  rwd_cal_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [8:0] bcd_step(input logic [7:0] v,
                                          input logic [7:0] last,
                                          input logic [7:0] first);
    if (v >= last)
      bcd_step = {1'b1, first};
    else if (v[3:0] == 4'h9)
      bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
    else
      bcd_step = {1'b0, v + BCD_ONE};
  endfunction

  // Year is BCD; valid leap rule up to the end of the century
  function automatic logic [7:0] month_end(input logic [7:0] m,
                                           input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    if (m == FEB)
      month_end = leap ? 8'h29 : 8'h28;
    else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11)
      month_end = 8'h30;
    else
      month_end = 8'h31;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic [8:0] r;
    r = '0;
    next_st = st;
    if (load)
      next_st.img = load_image & TIME_MASK;
    else if (tick)
    begin
      r = bcd_step(st.img[B_SEC +: 8], MINSEC_LAST, BCD_ZERO);
      next_st.img[B_SEC +: 8] = r[7:0];
      if (r[8])
      begin
        r = bcd_step(st.img[B_MIN +: 8], MINSEC_LAST, BCD_ZERO);
        next_st.img[B_MIN +: 8] = r[7:0];
        if (r[8])
        begin
          r = bcd_step(st.img[B_HOUR +: 8], HOUR_LAST, BCD_ZERO);
          next_st.img[B_HOUR +: 8] = r[7:0];
          if (r[8])
          begin
            r = bcd_step(st.img[B_WDAY +: 8], WDAY_LAST, BCD_ONE);
            next_st.img[B_WDAY +: 8] = r[7:0];
            r = bcd_step(st.img[B_DATE +: 8],
                         month_end(st.img[B_MONTH +: 8],
                                   st.img[B_YEAR +: 8]), BCD_ONE);
            next_st.img[B_DATE +: 8] = r[7:0];
            if (r[8])
            begin
              r = bcd_step(st.img[B_MONTH +: 8], MONTH_LAST, BCD_ONE);
              next_st.img[B_MONTH +: 8] = r[7:0];
              if (r[8])
              begin
                r = bcd_step(st.img[B_YEAR +: 8], YEAR_LAST, BCD_ZERO);
                next_st.img[B_YEAR +: 8] = r[7:0];
                if (r[8])
                begin
                  r = bcd_step(st.img[B_CENT +: 8], CENT_LAST, BCD_ZERO);
                  next_st.img[B_CENT +: 8] = r[7:0];
                end
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign time_image = st.img;
endmodule
`default_nettype wire

// ### rtl/rwd_core.sv
// Function
// - Seconds bit 7 set halts the crystal divider; clear lets it run.
// - Control bit 6 set freezes updates of the visible time bytes.
// - A read hold shows the count current when the hold began.
// - Internal counters keep advancing while the visible copy is frozen.
// - Visible copy refreshes 500us after the read hold clears, within 1s.
// - Control bit 7 freezes the visible bytes so the host loads a time.
// - Clearing control bit 7 copies the host's bytes into the counters.
// - Pin toggles at 512 Hz in test mode when its enables allow.
// - Power-up clears the frequency test bit; here only reset_n clears it, vcc_good rising leaves it.
// - Mask bits pick once per second, or seconds/minutes/hours/date matches.
// - Undefined mask patterns fire the alarm once per second.
// - A match sets the alarm flag; with its enable it pulls the pin.
// - Any access to the flags byte releases the alarm pin.
// - Flags access clears the alarm flag only at the access end.
// - On battery the alarm pulls the pin only with both enables set.
// - Power-up clears both alarm enables; matches still set the flag.
// - Watchdog period is multiplier times 1/16, 1/4, 1 or 4 seconds.
// - Expiry sets the watchdog flag, held until a flags read ends or a watchdog register access.
// - Steering bit zero routes a watchdog timeout onto the pin.
// - Any watchdog register access restarts the watchdog period.
// - Watchdog register 00h disables the watchdog completely.
// - Power-up clears steering, multiplier, resolution and alarm enables; vcc_good rising clears only the alarm enables, reset_n all.
`timescale 1ns/100ps
`default_nettype none
module rwd_core
  import rwd_pkg::*;
#(
  parameter int READ_RELEASE_CYCLES = READ_RELEASE_CYC
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe,
  input wire logic xtal_in,
  input wire logic vcc_good,
  input wire logic battery_low,
  output logic event_test_out,
  output logic event_test_oe
);
  localparam int SYNC_W = ADDR_W + 14;

  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic xtal_d;
    logic vcc_d;
    logic [DIV_W-1:0] div;
    logic tick_d;
    logic [63:0] ext;
    logic wr_hold;
    logic rd_hold;
    logic halt;
    logic ftest;
    logic [31:0] alarm;
    logic [7:0] alm_en;
    logic [7:0] wd_reg;
    logic [7:0] spare;
    logic af;
    logic wf;
    logic alm_int;
    logic pin_low;
    logic [WD_CNT_W-1:0] wd_cnt;
    logic [31:0] rel_cnt;
    logic acc_on;
    logic acc_wr;
    logic [3:0] acc_ofs;
    logic [7:0] acc_data;
    logic [7:0] dq_out;
    logic dq_oe;
  } rwd_state_t;

  rwd_state_t st;
  rwd_state_t next_st;

  logic [ADDR_W-1:0] s_addr;
  logic s_ce_n, s_oe_n, s_we_n, s_xtal, s_vcc, s_bat;
  logic [7:0] s_dq;
  logic run_edge, tick, acc_now, acc_start, acc_end, wr_end;
  logic fl_start, fl_end, wd_start, wd_expire, alarm_hit, load_cal;
  logic copy_ext, ft_tone, vcc_rise;
  logic [WD_MULT_W-1:0] mult;
  logic [WD_CNT_W-1:0] wd_limit;
  logic [3:0] need, eq;
  logic [63:0] cal_time;

  ////////////////////////////////////////////////////////////////////////////
  // Which comparisons a mask pattern asks for: {date, hour, min, sec}
  function automatic logic [3:0] match_need(input logic [3:0] am);
    unique case (am)
      AM_SEC:  match_need = 4'b0001;
      AM_MIN:  match_need = 4'b0011;
      AM_HOUR: match_need = 4'b0111;
      AM_DATE: match_need = 4'b1111;
      default: match_need = 4'b0000;
    endcase
  endfunction

  function automatic logic is_ofs(input logic [3:0] idx,
                                  input logic [18:0] ofs);
    is_ofs = (idx == ofs[3:0]);
  endfunction

  function automatic logic [7:0] rd_byte(input rwd_state_t s,
                                         input logic [3:0] idx,
                                         input logic bat);
    logic [7:0] b;
    b = s.ext[8 * idx[2:0] +: 8];
    if (idx[3])
    begin
      if (is_ofs(idx, OFS_CLK_CTRL))
      begin
        b[WR_HOLD_BIT] = s.wr_hold;
        b[RD_HOLD_BIT] = s.rd_hold;
      end
      if (is_ofs(idx, OFS_SEC_COUNT))
        b[HALT_BIT] = s.halt;
      if (is_ofs(idx, OFS_WDAY_COUNT))
        b[FTEST_BIT] = s.ftest;
    end
    else if (is_ofs(idx, OFS_FLAGS))
    begin
      b = 8'h00;
      b[WF_BIT] = s.wf;
      b[AF_BIT] = s.af;
      b[BLF_BIT] = bat;
    end
    else if (is_ofs(idx, OFS_SPARE))
      b = s.spare;
    else if (is_ofs(idx, OFS_ALM_EN))
      b = s.alm_en;
    else if (is_ofs(idx, OFS_WD_SETTING))
      b = s.wd_reg;
    else
      b = s.alarm[8 * 2'(idx[1:0] - OFS_ALM_SEC[1:0]) +: 8];
    rd_byte = b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pins come from another timing world: two flops before any use
  assign {s_addr, s_ce_n, s_oe_n, s_we_n, s_dq, s_xtal, s_vcc, s_bat} =
    st.sync2;

  assign run_edge = s_xtal & ~st.xtal_d & ~st.halt;
  assign tick = run_edge & (st.div == {DIV_W{1'b1}});
  assign vcc_rise = s_vcc & ~st.vcc_d;

  // Bus is blocked while the supply is below the trip point
  assign acc_now = (s_addr[ADDR_W-1:4] == OFS_FLAGS[ADDR_W-1:4]) & ~s_ce_n &
                   (~s_oe_n | ~s_we_n) & s_vcc;
  assign acc_start = acc_now & ~st.acc_on;
  assign acc_end = st.acc_on & ~acc_now;
  assign wr_end = acc_end & st.acc_wr;
  assign fl_start = acc_start & is_ofs(s_addr[3:0], OFS_FLAGS);
  assign fl_end = acc_end & is_ofs(st.acc_ofs, OFS_FLAGS);
  assign wd_start = acc_start & is_ofs(s_addr[3:0], OFS_WD_SETTING);
  assign load_cal = wr_end & is_ofs(st.acc_ofs, OFS_CLK_CTRL) & st.wr_hold &
                    ~st.acc_data[WR_HOLD_BIT];

  // Period counted in crystal edges: mult * 2048 << (2 * resolution)
  assign mult = st.wd_reg[WD_MULT_LSB +: WD_MULT_W];
  assign wd_limit = WD_CNT_W'({17'd0, mult} <<
                    (SIXTEENTH_SHIFT + 2 * int'(st.wd_reg[1:0])));
  assign wd_expire = run_edge & (mult != '0) & ~wd_start &
                     (st.wd_cnt == wd_limit - 22'd1);

  assign need = match_need({st.alarm[24 + AM_BIT], st.alarm[16 + AM_BIT],
                            st.alarm[8 + AM_BIT], st.alarm[AM_BIT]});
  assign eq = {cal_time[B_DATE +: 6] == st.alarm[29:24],
               cal_time[B_HOUR +: 6] == st.alarm[21:16],
               cal_time[B_MIN +: 7] == st.alarm[14:8],
               cal_time[B_SEC +: 7] == st.alarm[6:0]};
  assign alarm_hit = st.tick_d & ((eq & need) == need);

  // Visible copy follows the counters unless a hold is in force
  assign copy_ext = ~st.wr_hold & ((st.rel_cnt == 32'd1) |
                    (st.tick_d & ~st.rd_hold & (st.rel_cnt == '0)));
  assign ft_tone = st.ftest & ~st.alm_en[AIE_BIT] & ~st.halt &
                   (st.wd_reg[WDS_BIT] | (st.wd_reg == 8'h00)) &
                   st.div[TEST_DIV_BIT];

  rwd_calendar u_calendar (
    .clk(clk),
    .reset_n(reset_n),
    .tick(tick),
    .load(load_cal),
    .load_image(next_st.ext),
    .time_image(cal_time)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_st = st;
    next_st.sync1 = {addr, ce_n, oe_n, we_n, dq_in, xtal_in, vcc_good,
                     battery_low};
    next_st.sync2 = st.sync1;
    next_st.xtal_d = s_xtal;
    next_st.vcc_d = s_vcc;
    next_st.tick_d = tick;
    if (run_edge)
      next_st.div = st.div + 1'b1;
    if (copy_ext)
      next_st.ext = cal_time;
    if (st.rel_cnt != '0)
      next_st.rel_cnt = st.rel_cnt - 32'd1;

    // Access tracking; writes land when the access ends
    next_st.acc_on = acc_now;
    if (acc_now)
    begin
      next_st.acc_ofs = s_addr[3:0];
      next_st.acc_wr = (acc_start ? 1'b0 : st.acc_wr) | ~s_we_n;
      if (!s_we_n)
        next_st.acc_data = s_dq;
    end
    next_st.dq_out = rd_byte(st, s_addr[3:0], s_bat);
    next_st.dq_oe = acc_now & ~s_oe_n & s_we_n;

    // Watchdog
    if (wd_start || mult == '0 || wd_expire)
      next_st.wd_cnt = '0;
    else if (run_edge)
      next_st.wd_cnt = st.wd_cnt + 1'b1;
    if (wd_start || (fl_end && !st.acc_wr))
      next_st.wf = 1'b0;
    if (wd_expire)
      next_st.wf = 1'b1;

    // Alarm: clears first so a same-cycle event wins
    if (fl_start)
      next_st.alm_int = 1'b0;
    if (fl_end)
      next_st.af = 1'b0;
    if (alarm_hit)
    begin
      next_st.af = 1'b1;
      if (st.alm_en[AIE_BIT] && (s_vcc || st.alm_en[ABE_BIT]))
        next_st.alm_int = 1'b1;
    end
    if (vcc_rise)
    begin
      next_st.alm_en[AIE_BIT] = 1'b0;
      next_st.alm_en[ABE_BIT] = 1'b0;
    end

    // Register writes
    if (wr_end)
    begin
      if (st.acc_ofs[3])
        next_st.ext[8 * st.acc_ofs[2:0] +: 8] =
          st.acc_data & TIME_MASK[8 * st.acc_ofs[2:0] +: 8];
      if (is_ofs(st.acc_ofs, OFS_CLK_CTRL))
      begin
        next_st.wr_hold = st.acc_data[WR_HOLD_BIT];
        next_st.rd_hold = st.acc_data[RD_HOLD_BIT];
        if (st.acc_data[RD_HOLD_BIT])
          next_st.rel_cnt = '0;
        else if (st.rd_hold)
          next_st.rel_cnt = 32'(READ_RELEASE_CYCLES);
      end
      if (is_ofs(st.acc_ofs, OFS_SEC_COUNT))
        next_st.halt = st.acc_data[HALT_BIT];
      if (is_ofs(st.acc_ofs, OFS_WDAY_COUNT))
        next_st.ftest = st.acc_data[FTEST_BIT];
      if (is_ofs(st.acc_ofs, OFS_SPARE))
        next_st.spare = st.acc_data;
      if (is_ofs(st.acc_ofs, OFS_ALM_EN))
        next_st.alm_en = st.acc_data;
      if (is_ofs(st.acc_ofs, OFS_WD_SETTING))
        next_st.wd_reg = st.acc_data;
      if (!st.acc_ofs[3] && st.acc_ofs[2:0] >= OFS_ALM_SEC[2:0] &&
          st.acc_ofs[2:0] < OFS_ALM_EN[2:0])
        next_st.alarm[8 * 2'(st.acc_ofs[1:0] - OFS_ALM_SEC[1:0]) +: 8] =
          st.acc_data;
    end

    // Open drain: pulled low for alarm, watchdog or test tone
    next_st.pin_low = st.alm_int | (st.wf & ~st.wd_reg[WDS_BIT]) |
                      ft_tone;
  end

  // Supply application is the asynchronous reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= '0;
      st.ftest <= FTEST_RST;
      st.wd_reg <= WD_SETTING_RST;
      st.alm_en <= ALM_EN_RST;
    end
    else
      st <= next_st;
  end

  assign dq_out = st.dq_out;
  assign dq_oe = st.dq_oe;
  assign event_test_out = 1'b0;
  assign event_test_oe = st.pin_low;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  chk_halt_freeze: assert property (st.halt |=> $stable(st.div))
    else $error("divider moved while halted");
  chk_read_freeze: assert property (
    st.rd_hold && !wr_end && st.rel_cnt == '0 |=> $stable(st.ext))
    else $error("visible time changed during read hold");
  chk_count_runs: assert property (
    tick && st.rd_hold && !load_cal |=> cal_time != $past(cal_time))
    else $error("counters stopped under hold");
  chk_release_copy: assert property (
    st.rel_cnt == 32'd1 && !st.wr_hold && !wr_end
    |=> st.ext == $past(cal_time))
    else $error("no refresh after read hold release");
  chk_write_load: assert property (load_cal |=> cal_time == st.ext)
    else $error("written time not loaded");
  chk_alarm_flag: assert property (alarm_hit |=> st.af)
    else $error("alarm match did not set flag");
  chk_flag_release: assert property (
    fl_start && !alarm_hit |=> !st.alm_int ##1 (!st.pin_low || st.wf ||
    st.ftest || st.alm_int))
    else $error("flags access did not release pin");
  chk_af_clear: assert property (fl_end && !alarm_hit |=> !st.af)
    else $error("alarm flag not cleared at access end");
  chk_wd_restart: assert property (wd_start |=> st.wd_cnt == '0)
    else $error("watchdog not restarted by access");
  chk_wd_off: assert property (
    st.wd_reg == 8'h00 && !st.wf |=> !st.wf)
    else $error("disabled watchdog timed out");
  chk_pup_clear: assert property (
    vcc_rise |=> !st.alm_en[AIE_BIT] && !st.alm_en[ABE_BIT])
    else $error("power-up left alarm enables set");

  cov_alarm_pin: cover property (alarm_hit ##1 st.alm_int ##1 st.pin_low);
  cov_wd_expire: cover property (wd_expire ##1 st.wf);
  cov_read_release: cover property (st.rel_cnt == 32'd1);
  cov_write_load: cover property (load_cal);
endmodule
`default_nettype wire

// ### tb/rwd_host.sv
`timescale 1ns/100ps
`default_nettype none
module rwd_host
  import rwd_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe,
  output logic [ADDR_W-1:0] addr,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [7:0] dq_in
);
  initial
  begin
    addr = '0;
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    dq_in = 8'h00;
  end
  // Released lines show the inverse, so stale values cannot fake a match
  task automatic drop();
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    addr = ~addr;
    dq_in = ~dq_in;
    repeat (5) @(posedge clk);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    dq_in = d;
    ce_n = 1'b0;
    we_n = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    drop();
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d,
                    output bit ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge clk);
    #1;
    addr = a;
    ce_n = 1'b0;
    oe_n = 1'b0;
    // Sample just after the edge, once the registered outputs have settled
    for (int i = 0; i < 8 && !ok; i++)
    begin
      @(posedge clk);
      #1;
      ok = (dq_oe === 1'b1);
      d = dq_out;
    end
    drop();
  endtask
endmodule
`default_nettype wire

// ### tb/rwd_core_test.sv
`timescale 1ns/100ps
`default_nettype none
module rwd_core_test;
  import rwd_pkg::*;
  logic clk = 0;
  logic reset_n = 0;
  logic xtal_in = 0;
  logic battery_low = 0;
  logic vcc_good = 1;
  logic [ADDR_W-1:0] addr;
  logic ce_n, oe_n, we_n, dq_oe, event_test_out, event_test_oe;
  logic [7:0] dq_in, dq_out, rv, s, m;
  logic [31:0] seed = 32'h7614;
  int bad_count = 0;
  int compares = 0;
  int n;
  bit ok;
  localparam logic [18:0] TA [7] = '{OFS_WDAY_COUNT, OFS_ALM_EN, OFS_ALM_EN,
    OFS_WD_SETTING, OFS_SEC_COUNT, OFS_SEC_COUNT, OFS_WDAY_COUNT};
  localparam logic [7:0] TD [7] = '{8'h40, 8'h80, 8'h00, 8'h80, 8'h80,
    8'h00, 8'h00};
  localparam bit TON [7] = '{1, 0, 1, 1, 0, 1, 0};
  always #10 clk = ~clk;
  // Crystal edges land on falling clk edges, four clk cycles per period
  always #40 xtal_in = ~xtal_in;
  rwd_core #(.READ_RELEASE_CYCLES(20)) DUT (.clk(clk), .reset_n(reset_n),
    .addr(addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .xtal_in(xtal_in), .vcc_good(vcc_good),
    .battery_low(battery_low), .event_test_out(event_test_out),
    .event_test_oe(event_test_oe));
  rwd_host host (.clk(clk), .dq_out(dq_out), .dq_oe(dq_oe), .addr(addr),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_in(dq_in));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction
  task automatic end_sim();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rdc(input string what, input logic [18:0] a,
                     input logic [7:0] exp);
    host.rd(a, rv, ok);
    check(what, {23'h0, ok, rv}, {23'h0, 1'b1, exp});
    if (!ok)
      end_sim();
  endtask
  // Counts pin transitions over 2048 cycles; 512 Hz gives 16
  task automatic tone(input bit on);
    logic p;
    int t;
    t = 0;
    repeat (300) @(posedge clk);
    p = event_test_oe;
    repeat (2048)
    begin
      @(posedge clk);
      if (event_test_oe !== p)
        t++;
      p = event_test_oe;
    end
    check("tone", on ? 32'(t >= 15 && t <= 17) : 32'(t == 0), 32'h1);
  endtask
  // Cycles from now until the watchdog pulls the pin, bounded
  task automatic wdw(input int exp);
    n = 0;
    while (event_test_oe !== 1'b1 && n < 40000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 40000)
    begin
      bad_count++;
      end_sim();
    end
    check("wd_period", 32'(n > exp - 100 && n < exp + 100), 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = xs(seed);
    battery_low = seed[3];
    repeat (6) @(posedge clk);
    #1;
    reset_n = 1'b1;
    check("oe_reset", {31'h0, event_test_oe}, 32'h0);
    rdc("wd_reset", OFS_WD_SETTING, WD_SETTING_RST);
    rdc("alm_en_reset", OFS_ALM_EN, ALM_EN_RST);
    host.rd(OFS_WDAY_COUNT, rv, ok);
    check("ftest_reset", {31'h0, rv[FTEST_BIT]}, {31'h0, FTEST_RST});
    host.rd(19'h00010, rv, ok);
    check("unmapped", {31'h0, ok}, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      seed = xs(seed);
      host.wr(OFS_SPARE, seed[7:0]);
      rdc("spare", OFS_SPARE, seed[7:0]);
      host.wr(OFS_ALM_EN, seed[15:8]);
      rdc("alm_en", OFS_ALM_EN, seed[15:8]);
    end
    // Supply dip: bus refused, then power-up clears both alarm enables,
    // which the tone checks below also need
    host.wr(OFS_ALM_EN, 8'hff);
    @(posedge clk);
    #1;
    vcc_good = 1'b0;
    host.rd(OFS_ALM_EN, rv, ok);
    check("vcc_block", {31'h0, ok}, 32'h0);
    @(posedge clk);
    #1;
    vcc_good = 1'b1;
    repeat (4) @(posedge clk);
    rdc("pup_clear", OFS_ALM_EN, 8'h5f);
    for (int i = 0; i < 7; i++)
    begin
      host.wr(TA[i], TD[i]);
      tone(TON[i]);
    end
    for (int i = 0; i < 2; i++)
    begin
      seed = xs(seed);
      s = bcd(int'(seed[15:0] % 60));
      m = bcd(int'(seed[31:16] % 60));
      host.wr(OFS_CLK_CTRL, 8'h80);
      host.wr(OFS_SEC_COUNT, s);
      host.wr(OFS_MIN_COUNT, m);
      host.wr(OFS_CLK_CTRL, 8'h00);
      // Spoil the visible copy under a read hold; release shows the counters
      host.wr(OFS_CLK_CTRL, 8'h40);
      host.wr(OFS_SEC_COUNT, s ^ 8'h01);
      host.wr(OFS_CLK_CTRL, 8'h00);
      repeat (30) @(posedge clk);
      rdc("sec_load", OFS_SEC_COUNT, s);
      rdc("min_load", OFS_MIN_COUNT, m);
    end
    // Steering bit kept at zero whenever the watchdog is armed
    host.wr(OFS_WD_SETTING, 8'h04);
    wdw(8192);
    rdc("flags_wf", OFS_FLAGS, {1'b1, 2'b00, battery_low, 4'h0});
    @(posedge clk);
    check("wd_irq_clr", {31'h0, event_test_oe}, 32'h0);
    rdc("flags_clr", OFS_FLAGS, {3'b000, battery_low, 4'h0});
    host.wr(OFS_WD_SETTING, 8'h08);
    wdw(16384);
    host.wr(OFS_WD_SETTING, 8'h04);
    repeat (6000) @(posedge clk);
    rdc("wd_read", OFS_WD_SETTING, 8'h04);
    wdw(8192);
    host.wr(OFS_WD_SETTING, 8'h00);
    check("wd_acc_clr", {31'h0, event_test_oe}, 32'h0);
    n = 0;
    repeat (10000)
    begin
      @(posedge clk);
      if (event_test_oe !== 1'b0)
        n++;
    end
    check("wd_off", n, 32'h0);
    check("pin_level", {31'h0, event_test_out}, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
